// ### logic/cbs_exec.sv
// execution unit for call/return, compare/skip, branch, I/O bit, shift and T-flag operations
//
// Behaviour
// - direct call loads target, pushes return address, four cycles, flags untouched
// - compare-skip-equal skips next instruction on match; 1/2/3 cycles, no flags
// - compares subtract without writeback, update Z N V C H in one cycle
// - register bit skips skip on bit clear or set; 1/2/3 cycles
// - I/O bit skips skip on I/O bit clear or set; 1/2/3 cycles, no flags
// - branch on flag set adds offset plus one; two cycles taken, else one
// - branch on flag clear adds offset plus one when bit zero; no flags
// - signed ge branch taken when N xor V is zero
// - unsigned ge branches on carry zero, lower branches on carry one
// - half-carry branches test H for one or zero
// - interrupt-state branches test I for one or zero, flag untouched
// - I/O bit set writes only addressed bit to one in two cycles
// - I/O bit clear writes only addressed bit to zero in two cycles
// - logical right shift inserts zero at bit seven, updates Z C N V
// - rotate left moves carry into bit zero, bit seven into carry
// - rotate right moves carry into bit seven, bit zero into carry
// - arithmetic right shift keeps sign bit, updates Z C N V
// - bit store copies register bit into T only
// - bit load writes T into selected register bit, flags untouched
// - global interrupt on and off set or clear I in one cycle
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "cbs_map.svh"

module cbs_exec (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               op_valid,
  input  wire cbs_pkg::cbs_req_s  op_req,
  output logic                    busy_q,
  output logic                    done_q,
  output logic [15:0]             pc_q,
  output logic [7:0]              flags_q,
  output cbs_pkg::cbs_regwr_s     reg_wr_q,
  output cbs_pkg::cbs_iowr_s      io_wr_q,
  output logic                    stack_push_q,
  output logic [15:0]             stack_wdata_q,
  output logic                    stack_pop_q,
  input  wire logic [15:0]        stack_rdata,
  input  wire logic [3:0]         bus_addr,
  input  wire logic [7:0]         bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_rd,
  output logic [7:0]              bus_rdata_q
);
  import cbs_pkg::*;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  cbs_op_e     op;
  logic        accept;
  logic [7:0]  a;
  logic        c_in;
  logic        is_cmp;
  logic        is_skip;
  logic        is_branch;
  logic        is_shift;
  logic        is_return;
  logic        is_io_bit;

  assign op        = op_req.op;
  assign a         = op_req.rd_val;
  assign c_in      = flags_q[`CBS_FLAG_C];
  assign accept    = op_valid & ~busy_q;
  assign is_cmp    = (op == CBS_REGISTER_COMPARE) | (op == CBS_COMPARE_WITH_CARRY_IN)
                   | (op == CBS_COMPARE_IMMEDIATE);
  assign is_skip   = (op == CBS_COMPARE_SKIP_EQUAL) | (op == CBS_SKIP_REG_BIT_CLEAR)
                   | (op == CBS_SKIP_REG_BIT_SET) | (op == CBS_SKIP_IO_BIT_CLEAR)
                   | (op == CBS_SKIP_IO_BIT_SET);
  assign is_branch = (op >= CBS_BRANCH_FLAG_SET) & (op <= CBS_BRANCH_IRQ_OFF);
  assign is_shift  = (op >= CBS_LOGICAL_RIGHT_SHIFT) & (op <= CBS_ARITH_RIGHT_SHIFT);
  assign is_return = (op == CBS_SUBROUTINE_BACK) | (op == CBS_INTERRUPT_BACK);
  assign is_io_bit = (op == CBS_IO_BIT_SET_OP) | (op == CBS_IO_BIT_CLEAR_OP);

  // ------------------------------------------------------------
  // compare: subtraction without writeback
  // ------------------------------------------------------------
  logic [7:0] cmp_b;
  logic       cmp_cin;
  logic [7:0] diff;
  logic       cmp_c;
  logic       cmp_h;
  logic       cmp_v;
  logic       cmp_z;

  assign cmp_b   = (op == CBS_COMPARE_IMMEDIATE) ? op_req.imm : op_req.rr_val;
  assign cmp_cin = (op == CBS_COMPARE_WITH_CARRY_IN) & c_in;
  assign diff    = a - cmp_b - {7'h00, cmp_cin};
  assign cmp_c   = (~a[7] & cmp_b[7]) | (cmp_b[7] & diff[7]) | (diff[7] & ~a[7]);
  assign cmp_h   = (~a[3] & cmp_b[3]) | (cmp_b[3] & diff[3]) | (diff[3] & ~a[3]);
  assign cmp_v   = (a[7] & ~cmp_b[7] & ~diff[7]) | (~a[7] & cmp_b[7] & diff[7]);
  // with carry in, zero only stays set across a multi-byte compare
  assign cmp_z   = (diff == 8'h00)
                 & ((op != CBS_COMPARE_WITH_CARRY_IN) | flags_q[`CBS_FLAG_Z]);

  // ------------------------------------------------------------
  // shifts and rotates through carry
  // ------------------------------------------------------------
  logic [7:0] sh_res;
  logic       sh_c;
  logic       sh_n;

  assign sh_res = (op == CBS_LOGICAL_RIGHT_SHIFT) ? {1'b0, a[7:1]}
                : (op == CBS_ROTATE_LEFT_CARRY)   ? {a[6:0], c_in}
                : (op == CBS_ROTATE_RIGHT_CARRY)  ? {c_in, a[7:1]}
                :                                   {a[7], a[7:1]};
  assign sh_c   = (op == CBS_ROTATE_LEFT_CARRY) ? a[7] : a[0];
  assign sh_n   = sh_res[7];

  // ------------------------------------------------------------
  // branch and skip conditions
  // ------------------------------------------------------------
  logic br_cond;
  logic taken;
  logic skip_cond;
  logic skip;

  assign br_cond =
      (op == CBS_BRANCH_FLAG_SET)         ?  flags_q[op_req.flag_sel]
    : (op == CBS_BRANCH_FLAG_CLEAR)       ? ~flags_q[op_req.flag_sel]
    : (op == CBS_BRANCH_SIGNED_GE)        ? ~(flags_q[`CBS_FLAG_N] ^ flags_q[`CBS_FLAG_V])
    : (op == CBS_BRANCH_UNSIGNED_GE)      ? ~flags_q[`CBS_FLAG_C]
    : (op == CBS_BRANCH_UNSIGNED_LT)      ?  flags_q[`CBS_FLAG_C]
    : (op == CBS_BRANCH_HALF_CARRY_SET)   ?  flags_q[`CBS_FLAG_H]
    : (op == CBS_BRANCH_HALF_CARRY_CLEAR) ? ~flags_q[`CBS_FLAG_H]
    : (op == CBS_BRANCH_IRQ_ON)           ?  flags_q[`CBS_FLAG_I]
    :                                       ~flags_q[`CBS_FLAG_I];
  assign taken = is_branch & br_cond;

  assign skip_cond =
      (op == CBS_COMPARE_SKIP_EQUAL) ? (a == op_req.rr_val)
    : (op == CBS_SKIP_REG_BIT_CLEAR) ? ~a[op_req.bit_sel]
    : (op == CBS_SKIP_REG_BIT_SET)   ?  a[op_req.bit_sel]
    : (op == CBS_SKIP_IO_BIT_CLEAR)  ? ~op_req.io_val[op_req.bit_sel]
    :                                   op_req.io_val[op_req.bit_sel];
  assign skip = is_skip & skip_cond;

  // ------------------------------------------------------------
  // cycle count of the accepted operation
  // ------------------------------------------------------------
  logic [2:0] cyc_n;

  assign cyc_n = (op == CBS_DIRECT_CALL) ? `CBS_CYC_CALL
               : is_return               ? `CBS_CYC_RETURN
               : is_io_bit               ? `CBS_CYC_IO_BIT
               : taken                   ? `CBS_CYC_TWO
               : skip                    ? (op_req.next_two_word ? `CBS_CYC_THREE
                                                                 : `CBS_CYC_TWO)
               :                           `CBS_CYC_ONE;

  // ------------------------------------------------------------
  // next program counter
  // ------------------------------------------------------------
  logic [15:0] pc_inc;
  logic [15:0] pc_off;
  logic [15:0] pc_n;

  assign pc_inc = pc_q + 16'h0001;
  assign pc_off = {{9{op_req.offset[6]}}, op_req.offset};
  assign pc_n   = (op == CBS_DIRECT_CALL) ? op_req.target
                : is_return               ? pc_q
                : taken                   ? pc_inc + pc_off
                : skip                    ? pc_inc + (op_req.next_two_word ? 16'h0002
                                                                           : 16'h0001)
                :                           pc_inc;

  // ------------------------------------------------------------
  // next status flags
  // ------------------------------------------------------------
  logic [7:0] fl_n;
  logic [7:0] fl_cmp;
  logic [7:0] fl_sh;
  logic [7:0] fl_t;

  assign fl_cmp = {flags_q[7:6], cmp_h, diff[7] ^ cmp_v, cmp_v, diff[7], cmp_z, cmp_c};
  assign fl_sh  = {flags_q[7:5], sh_n ^ (sh_n ^ sh_c), sh_n ^ sh_c, sh_n,
                   sh_res == 8'h00, sh_c};
  assign fl_t   = {flags_q[7], a[op_req.bit_sel], flags_q[5:0]};
  assign fl_n   = is_cmp                             ? fl_cmp
                : is_shift                           ? fl_sh
                : (op == CBS_BIT_TO_TRANSFER_FLAG)   ? fl_t
                : (op == CBS_INTERRUPT_BACK)         ? {1'b1, flags_q[6:0]}
                : (op == CBS_IRQ_GLOBAL_ON)          ? {1'b1, flags_q[6:0]}
                : (op == CBS_IRQ_GLOBAL_OFF)         ? {1'b0, flags_q[6:0]}
                :                                      flags_q;

  // ------------------------------------------------------------
  // register and I/O write data
  // ------------------------------------------------------------
  logic [7:0]  bit_mask;
  cbs_regwr_s  reg_wr_n;
  cbs_iowr_s   io_wr_n;

  assign bit_mask      = 8'h01 << op_req.bit_sel;
  assign reg_wr_n.en   = accept & (is_shift | (op == CBS_TRANSFER_FLAG_TO_BIT));
  assign reg_wr_n.idx  = op_req.rd_idx;
  assign reg_wr_n.data = is_shift ? sh_res
                       : flags_q[`CBS_FLAG_T] ? (a | bit_mask)
                       :                        (a & ~bit_mask);
  assign io_wr_n.en    = accept & is_io_bit;
  assign io_wr_n.addr  = op_req.io_addr;
  assign io_wr_n.data  = (op == CBS_IO_BIT_SET_OP) ? (op_req.io_val | bit_mask)
                       :                             (op_req.io_val & ~bit_mask);

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  logic [2:0] cnt_q;
  logic       back_pop_q;
  logic       back_load_q;
  logic       io_pend_q;
  cbs_iowr_s  io_hold_q;
  logic       bus_flags_wr;

  assign bus_flags_wr = bus_wr & (bus_addr == `CBS_OFF_FLAGS);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= 3'h0;
    end else if (accept) begin
      busy_q <= (cyc_n != `CBS_CYC_ONE);
      done_q <= (cyc_n == `CBS_CYC_ONE);
      cnt_q  <= cyc_n - 3'h1;
    end else if (busy_q) begin
      busy_q <= (cnt_q != 3'h1);
      done_q <= (cnt_q == 3'h1);
      cnt_q  <= cnt_q - 3'h1;
    end else begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= `CBS_PC_RST;
    end else if (back_load_q) begin
      pc_q <= stack_rdata;
    end else if (accept) begin
      pc_q <= pc_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= `CBS_FLAGS_RST;
    end else if (accept) begin
      flags_q <= fl_n;
    end else if (bus_flags_wr) begin
      flags_q <= bus_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_push_q  <= 1'b0;
      stack_wdata_q <= 16'h0000;
      stack_pop_q   <= 1'b0;
      back_pop_q    <= 1'b0;
      back_load_q   <= 1'b0;
    end else begin
      stack_push_q  <= accept & (op == CBS_DIRECT_CALL);
      stack_wdata_q <= pc_q + 16'h0002;
      stack_pop_q   <= accept & is_return;
      back_pop_q    <= accept & is_return;
      back_load_q   <= back_pop_q;
    end
  end

  // I/O write lands in the second cycle of the bit operation
  always_ff @(posedge clk) begin
    if (rst) begin
      io_pend_q <= 1'b0;
      io_hold_q <= '0;
      io_wr_q   <= '0;
      reg_wr_q  <= '0;
    end else begin
      io_pend_q <= io_wr_n.en;
      io_hold_q <= io_wr_n;
      io_wr_q   <= io_pend_q ? io_hold_q : '0;
      reg_wr_q  <= reg_wr_n;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic [7:0] bus_rsel;

  assign bus_rsel = (bus_addr == `CBS_OFF_FLAGS) ? flags_q
                  : (bus_addr == `CBS_OFF_PC_LO) ? pc_q[7:0]
                  : (bus_addr == `CBS_OFF_PC_HI) ? pc_q[15:8]
                  :                                8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata_q <= 8'h00;
    end else begin
      bus_rdata_q <= bus_rd ? bus_rsel : 8'h00;
    end
  end

endmodule

// ### logic/cbs_map.svh
// offsets, flag positions, reset values and cycle counts of the branch/bit/shift unit
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

// status flag positions
`define CBS_FLAG_C 0
`define CBS_FLAG_Z 1
`define CBS_FLAG_N 2
`define CBS_FLAG_V 3
`define CBS_FLAG_S 4
`define CBS_FLAG_H 5
`define CBS_FLAG_T 6
`define CBS_FLAG_I 7

// register port offsets
`define CBS_OFF_FLAGS 4'h0
`define CBS_OFF_PC_LO 4'h1
`define CBS_OFF_PC_HI 4'h2

// reset values
`define CBS_FLAGS_RST 8'h00
`define CBS_PC_RST    16'h0000

// cycle counts per operation
`define CBS_CYC_ONE      3'h1
`define CBS_CYC_TWO      3'h2
`define CBS_CYC_THREE    3'h3
`define CBS_CYC_CALL     3'h4
`define CBS_CYC_RETURN   3'h4
`define CBS_CYC_IO_BIT   3'h2

`endif

// ### logic/cbs_pkg.sv
// types of the branch/bit/shift execution unit
package cbs_pkg;

  typedef enum logic [4:0] {
    CBS_DIRECT_CALL,
    CBS_SUBROUTINE_BACK,
    CBS_INTERRUPT_BACK,
    CBS_COMPARE_SKIP_EQUAL,
    CBS_REGISTER_COMPARE,
    CBS_COMPARE_WITH_CARRY_IN,
    CBS_COMPARE_IMMEDIATE,
    CBS_SKIP_REG_BIT_CLEAR,
    CBS_SKIP_REG_BIT_SET,
    CBS_SKIP_IO_BIT_CLEAR,
    CBS_SKIP_IO_BIT_SET,
    CBS_BRANCH_FLAG_SET,
    CBS_BRANCH_FLAG_CLEAR,
    CBS_BRANCH_SIGNED_GE,
    CBS_BRANCH_UNSIGNED_GE,
    CBS_BRANCH_UNSIGNED_LT,
    CBS_BRANCH_HALF_CARRY_SET,
    CBS_BRANCH_HALF_CARRY_CLEAR,
    CBS_BRANCH_IRQ_ON,
    CBS_BRANCH_IRQ_OFF,
    CBS_IO_BIT_SET_OP,
    CBS_IO_BIT_CLEAR_OP,
    CBS_LOGICAL_RIGHT_SHIFT,
    CBS_ROTATE_LEFT_CARRY,
    CBS_ROTATE_RIGHT_CARRY,
    CBS_ARITH_RIGHT_SHIFT,
    CBS_BIT_TO_TRANSFER_FLAG,
    CBS_TRANSFER_FLAG_TO_BIT,
    CBS_IRQ_GLOBAL_ON,
    CBS_IRQ_GLOBAL_OFF
  } cbs_op_e;

  typedef struct packed {
    cbs_op_e     op;
    logic [7:0]  rd_val;
    logic [7:0]  rr_val;
    logic [7:0]  imm;
    logic [4:0]  rd_idx;
    logic [2:0]  bit_sel;
    logic [2:0]  flag_sel;
    logic [4:0]  io_addr;
    logic [7:0]  io_val;
    logic [6:0]  offset;
    logic [15:0] target;
    logic        next_two_word;
  } cbs_req_s;

  typedef struct packed {
    logic       en;
    logic [4:0] idx;
    logic [7:0] data;
  } cbs_regwr_s;

  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } cbs_iowr_s;

endpackage

// ### tb/cbs_exec_sva.sv
// concurrent checks on the ports of the branch/bit/shift execution unit
`timescale 1ns/1ns
module cbs_exec_sva (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                op_valid,
  input wire cbs_pkg::cbs_req_s   op_req,
  input wire logic                busy_q,
  input wire logic                done_q,
  input wire logic [15:0]         pc_q,
  input wire logic [7:0]          flags_q,
  input wire cbs_pkg::cbs_regwr_s reg_wr_q,
  input wire cbs_pkg::cbs_iowr_s  io_wr_q,
  input wire logic                stack_push_q,
  input wire logic [15:0]         stack_wdata_q,
  input wire logic                stack_pop_q,
  input wire logic [15:0]         stack_rdata,
  input wire logic [3:0]          bus_addr,
  input wire logic [7:0]          bus_wdata,
  input wire logic                bus_wr,
  input wire logic                bus_rd,
  input wire logic [7:0]          bus_rdata_q
);
  import cbs_pkg::*;
  cbs_req_s    req_q;
  cbs_req_s    req2_q;
  logic [15:0] pc_p_q;
  logic [7:0]  fl_p_q;
  wire logic   acc = op_valid && !busy_q;
  wire logic   one_cyc = op_req.op inside {[CBS_REGISTER_COMPARE:CBS_COMPARE_IMMEDIATE],
                                           [CBS_LOGICAL_RIGHT_SHIFT:CBS_IRQ_GLOBAL_OFF]};
  wire logic   is_br = op_req.op inside {[CBS_BRANCH_FLAG_SET:CBS_BRANCH_IRQ_OFF]};
  wire logic   is_io = op_req.op inside {CBS_IO_BIT_SET_OP, CBS_IO_BIT_CLEAR_OP};
  wire logic [7:0] io_mask = 8'h01 << req2_q.bit_sel;

  // ----------------------------------------
  // operand and state history
  // ----------------------------------------
  always_ff @(posedge clk) begin
    req_q  <= op_req;
    req2_q <= req_q;
    pc_p_q <= pc_q;
    fl_p_q <= flags_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_call_tail;
    busy_q [*3] ##1 (done_q && !busy_q);
  endsequence
  sequence s_back_tail;
    stack_pop_q ##2 (pc_q == $past(stack_rdata)) ##1 (done_q && !busy_q);
  endsequence

  a_call_pc_push:
  assert property (acc && op_req.op == CBS_DIRECT_CALL |=> pc_q == req_q.target &&
    stack_push_q && stack_wdata_q == pc_p_q + 16'h0002 && flags_q == fl_p_q)
    else $error("call did not load target and push return address");
  a_call_four_cyc:
  assert property (acc && op_req.op == CBS_DIRECT_CALL |=> s_call_tail)
    else $error("call did not finish in four cycles");
  a_back_restore_pc:
  assert property (acc && op_req.op inside {CBS_SUBROUTINE_BACK, CBS_INTERRUPT_BACK}
    |=> s_back_tail) else $error("return did not restore pc in four cycles");
  a_iret_sets_irq:
  assert property (acc && op_req.op == CBS_INTERRUPT_BACK |=> flags_q[7])
    else $error("interrupt return left interrupt enable clear");
  a_one_cyc_done:
  assert property (acc && one_cyc |=> done_q && !busy_q)
    else $error("single-cycle operation not done after one cycle");
  a_branch_taken_pc:
  assert property (acc && op_req.op == CBS_BRANCH_FLAG_SET && flags_q[op_req.flag_sel]
    |=> pc_q == pc_p_q + 16'h0001 + {{9{req_q.offset[6]}}, req_q.offset} ##1 done_q)
    else $error("taken branch pc or timing wrong");
  a_branch_keeps_flags:
  assert property (acc && is_br |=> flags_q == fl_p_q)
    else $error("branch changed status flags");
  a_io_bit_write:
  assert property (acc && is_io |-> ##2 io_wr_q.en && io_wr_q.addr == req2_q.io_addr &&
    io_wr_q.data == (req2_q.op == CBS_IO_BIT_SET_OP ? req2_q.io_val | io_mask :
    req2_q.io_val & ~io_mask) && done_q) else $error("io bit write wrong");
  a_bit_store_t:
  assert property (acc && op_req.op == CBS_BIT_TO_TRANSFER_FLAG |=> flags_q ==
    {fl_p_q[7], req_q.rd_val[req_q.bit_sel], fl_p_q[5:0]})
    else $error("bit store did not copy bit into transfer flag only");
  a_irq_set_clr:
  assert property (acc && op_req.op inside {CBS_IRQ_GLOBAL_ON, CBS_IRQ_GLOBAL_OFF}
    |=> flags_q == {req_q.op == CBS_IRQ_GLOBAL_ON, fl_p_q[6:0]})
    else $error("interrupt enable flag not set or cleared");
endmodule

bind cbs_exec cbs_exec_sva i_cbs_exec_sva (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_req(op_req), .busy_q(busy_q),
  .done_q(done_q), .pc_q(pc_q), .flags_q(flags_q), .reg_wr_q(reg_wr_q), .io_wr_q(io_wr_q),
  .stack_push_q(stack_push_q), .stack_wdata_q(stack_wdata_q), .stack_pop_q(stack_pop_q),
  .stack_rdata(stack_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q)
);

// ### tb/cbs_exec_tb.sv
// self-checking bench for the branch/bit/shift execution unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cbs_exec_tb;
  import cbs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0;
  cbs_req_s    op_req = '0;
  logic        busy_q, done_q, stack_push_q, stack_pop_q;
  logic [15:0] pc_q, stack_wdata_q;
  logic [15:0] stack_rdata = 16'h0200;
  logic [7:0]  flags_q, bus_rdata_q, rv;
  logic [3:0]  bus_addr = 4'h0;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  cbs_regwr_s  reg_wr_q;
  cbs_iowr_s   io_wr_q;
  int          fail_count = 0;
  int          compares = 0;
  logic [15:0] pc_exp = 16'h0000;
  logic        tw = 1'b0;
  logic        poke = 1'b0;

  always #4 clk = ~clk;

  cbs_exec i_cbs_exec (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_req(op_req), .busy_q(busy_q),
    .done_q(done_q), .pc_q(pc_q), .flags_q(flags_q), .reg_wr_q(reg_wr_q), .io_wr_q(io_wr_q),
    .stack_push_q(stack_push_q), .stack_wdata_q(stack_wdata_q), .stack_pop_q(stack_pop_q),
    .stack_rdata(stack_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q)
  );

  // ----------------------------------------
  // register port and operation tasks
  // ----------------------------------------
  task automatic wrap_up;
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata_q;
  endtask

  task automatic check_regs(input logic [7:0] fe);
    bus_read(4'h0, rv);
    `CHK("flags", fe, rv)
    bus_read(4'h1, rv);
    `CHK("pc_lo", pc_exp[7:0], rv)
    bus_read(4'h2, rv);
    `CHK("pc_hi", pc_exp[15:8], rv)
  endtask

  task automatic run(input cbs_op_e op, input logic [7:0] a, b, input logic [2:0] s,
                     input logic [7:0] f, fe, input int cyc, input logic [7:0] wd);
    int         n;
    logic [7:0] wq;
    n  = 0;
    wq = 8'h00;
    bus_write(4'h0, f);
    @(posedge clk);
    op_valid             <= 1'b1;
    op_req.op            <= op;
    op_req.rd_val        <= a;
    op_req.rr_val        <= b;
    op_req.imm           <= b;
    op_req.io_val        <= b;
    op_req.bit_sel       <= s;
    op_req.flag_sel      <= s;
    op_req.next_two_word <= tw;
    stack_rdata          <= {8'h02, b};
    @(posedge clk);
    op_valid <= 1'b0;
    while (n < 10) begin
      #1;
      n++;
      if (reg_wr_q.en === 1'b1) `CHK("reg_idx", 5'h10, reg_wr_q.idx)
      if (reg_wr_q.en === 1'b1) wq = reg_wr_q.data;
      if (io_wr_q.en === 1'b1) wq = io_wr_q.data;
      if (done_q === 1'b1) break;
      @(posedge clk);
      // a request while busy must be ignored
      if (poke) op_valid <= (n == 1);
      if (poke) op_req.op <= CBS_IRQ_GLOBAL_ON;
    end
    if (done_q !== 1'b1) begin
      fail_count++;
      wrap_up();
    end else begin
      // offset is -2, so a taken branch lands one word back
      if (op == CBS_DIRECT_CALL) pc_exp = 16'h0123;
      else if (op inside {CBS_SUBROUTINE_BACK, CBS_INTERRUPT_BACK}) pc_exp = {8'h02, b};
      else if (op inside {[CBS_BRANCH_FLAG_SET:CBS_BRANCH_IRQ_OFF]} && cyc == 2) pc_exp--;
      else if (op inside {CBS_IO_BIT_SET_OP, CBS_IO_BIT_CLEAR_OP}) pc_exp++;
      else pc_exp = pc_exp + 16'(cyc);
      `CHK("cycles", cyc, n)
      `CHK("wdata", wd, wq)
      check_regs(fe);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    op_req.target  <= 16'h0123;
    op_req.offset  <= 7'h7E;
    op_req.io_addr <= 5'h1F;
    op_req.rd_idx  <= 5'h10;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check_regs(8'h00);
    bus_read(4'hF, rv);
    `CHK("unmapped", 8'h00, rv)
    bus_write(4'h1, 8'hAA);
    bus_write(4'h9, 8'h55);
    check_regs(8'h00);
    poke = 1'b1;
    run(CBS_DIRECT_CALL, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00, 4, 8'h00);
    poke = 1'b0;
    run(CBS_SUBROUTINE_BACK, 8'h00, 8'h40, 3'h0, 8'h21, 8'h21, 4, 8'h00);
    run(CBS_INTERRUPT_BACK, 8'h00, 8'h66, 3'h0, 8'h01, 8'h81, 4, 8'h00);
    run(CBS_REGISTER_COMPARE, 8'h10, 8'h20, 3'h0, 8'h00, 8'h15, 1, 8'h00);
    run(CBS_REGISTER_COMPARE, 8'h10, 8'h01, 3'h0, 8'h00, 8'h20, 1, 8'h00);
    run(CBS_REGISTER_COMPARE, 8'h80, 8'h01, 3'h0, 8'h00, 8'h38, 1, 8'h00);
    run(CBS_COMPARE_IMMEDIATE, 8'h20, 8'h20, 3'h0, 8'hC0, 8'hC2, 1, 8'h00);
    run(CBS_COMPARE_WITH_CARRY_IN, 8'h33, 8'h32, 3'h0, 8'h03, 8'h02, 1, 8'h00);
    run(CBS_COMPARE_WITH_CARRY_IN, 8'h33, 8'h33, 3'h0, 8'h00, 8'h00, 1, 8'h00);
    tw = 1'b1;
    run(CBS_COMPARE_SKIP_EQUAL, 8'h44, 8'h44, 3'h0, 8'h3F, 8'h3F, 3, 8'h00);
    run(CBS_SKIP_IO_BIT_SET, 8'h00, 8'h80, 3'h7, 8'h00, 8'h00, 3, 8'h00);
    tw = 1'b0;
    run(CBS_COMPARE_SKIP_EQUAL, 8'h44, 8'h44, 3'h0, 8'h00, 8'h00, 2, 8'h00);
    run(CBS_COMPARE_SKIP_EQUAL, 8'h44, 8'h45, 3'h0, 8'h00, 8'h00, 1, 8'h00);
    run(CBS_SKIP_REG_BIT_CLEAR, 8'hF7, 8'hF7, 3'h3, 8'h00, 8'h00, 2, 8'h00);
    run(CBS_SKIP_REG_BIT_SET, 8'hF7, 8'hF7, 3'h3, 8'h00, 8'h00, 1, 8'h00);
    run(CBS_SKIP_IO_BIT_CLEAR, 8'h00, 8'h01, 3'h0, 8'h00, 8'h00, 1, 8'h00);
    run(CBS_BRANCH_FLAG_SET, 8'h00, 8'h00, 3'h2, 8'h04, 8'h04, 2, 8'h00);
    run(CBS_BRANCH_FLAG_SET, 8'h00, 8'h00, 3'h2, 8'h00, 8'h00, 1, 8'h00);
    run(CBS_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 3'h6, 8'h00, 8'h00, 2, 8'h00);
    run(CBS_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 3'h2, 8'h04, 8'h04, 1, 8'h00);
    run(CBS_BRANCH_SIGNED_GE, 8'h00, 8'h00, 3'h0, 8'h0C, 8'h0C, 2, 8'h00);
    run(CBS_BRANCH_SIGNED_GE, 8'h00, 8'h00, 3'h0, 8'h04, 8'h04, 1, 8'h00);
    run(CBS_BRANCH_UNSIGNED_GE, 8'h00, 8'h00, 3'h0, 8'h01, 8'h01, 1, 8'h00);
    run(CBS_BRANCH_UNSIGNED_LT, 8'h00, 8'h00, 3'h0, 8'h01, 8'h01, 2, 8'h00);
    run(CBS_BRANCH_HALF_CARRY_SET, 8'h00, 8'h00, 3'h0, 8'h20, 8'h20, 2, 8'h00);
    run(CBS_BRANCH_HALF_CARRY_CLEAR, 8'h00, 8'h00, 3'h0, 8'h20, 8'h20, 1, 8'h00);
    run(CBS_BRANCH_IRQ_ON, 8'h00, 8'h00, 3'h0, 8'h80, 8'h80, 2, 8'h00);
    run(CBS_BRANCH_IRQ_OFF, 8'h00, 8'h00, 3'h0, 8'h80, 8'h80, 1, 8'h00);
    run(CBS_IO_BIT_SET_OP, 8'h00, 8'h5A, 3'h7, 8'h55, 8'h55, 2, 8'hDA);
    run(CBS_IO_BIT_CLEAR_OP, 8'h00, 8'h5A, 3'h1, 8'h55, 8'h55, 2, 8'h58);
    run(CBS_LOGICAL_RIGHT_SHIFT, 8'h81, 8'h00, 3'h0, 8'h00, 8'h19, 1, 8'h40);
    run(CBS_LOGICAL_RIGHT_SHIFT, 8'h01, 8'h00, 3'h0, 8'h00, 8'h1B, 1, 8'h00);
    run(CBS_ROTATE_LEFT_CARRY, 8'h81, 8'h00, 3'h0, 8'h01, 8'h19, 1, 8'h03);
    run(CBS_ROTATE_RIGHT_CARRY, 8'h02, 8'h00, 3'h0, 8'h01, 8'h0C, 1, 8'h81);
    run(CBS_ARITH_RIGHT_SHIFT, 8'h80, 8'h00, 3'h0, 8'h00, 8'h0C, 1, 8'hC0);
    run(CBS_BIT_TO_TRANSFER_FLAG, 8'h08, 8'h08, 3'h3, 8'h00, 8'h40, 1, 8'h00);
    run(CBS_TRANSFER_FLAG_TO_BIT, 8'h00, 8'h00, 3'h5, 8'h40, 8'h40, 1, 8'h20);
    run(CBS_IRQ_GLOBAL_ON, 8'h00, 8'h00, 3'h0, 8'h00, 8'h80, 1, 8'h00);
    run(CBS_IRQ_GLOBAL_OFF, 8'h00, 8'h00, 3'h0, 8'hFF, 8'h7F, 1, 8'h00);
    wrap_up();
  end
endmodule
